// ===== core/rss_pkg.sv
/*
  constants, types and state encodings shared by the reference select and
  switchover block. assumes a single 40 MHz core clock with synchronous reset.
*/
// Functional notes
// R1: synthesizer mode ignores both references; selection logic stays idle.
// R2: two-bit switch_policy picks manual-pin, manual-register, revertive or non-revertive.
// R3: manual-pin mode takes the active reference from the select pin level.
// R4: manual-register mode uses the select bit; lock when that input is valid.
// R5: manual mode with chosen input invalid enters holdover/free-run and flags loss.
// R6: manual mode returns to the chosen input as soon as it is valid again.
// R7: in manual mode only the controller changes references, by pin or bit.
// R8: automatic modes take the preferred reference from the select bit only.
// R9: automatic start locks to preferred input, ignoring the other until locked.
// R10: once locked stay on preferred; on its failure move to a valid other.
// R11: automatic mode with both inputs invalid enters holdover/free-run, flags loss.
// R12: leaving holdover with both inputs valid picks the select bit's input.
// R13: revertive mode returns to preferred input once valid, even if other valid.
// R14: non-revertive mode stays on non-preferred input while it remains valid.
// R15: after a switch, slew output phase at bounded rate until aligned.
// R16: phase correction only stretches output periods, never shortens them.
// R17: holdover or free-run freezes all output phase adjustment.
// R18: low-bandwidth holdover keeps the loop on the local crystal.
// R19: automatic modes leave holdover on whichever input becomes valid first.
// R20: leaving holdover uses the same phase-slope-limited switch procedure.
// R21: input invalid after three feedback edges without reference edge; edge clears.
// R22: lock indicator asserts after frequency lock, drops as soon as lost.
// R23: active-reference output reports which input drives the output.
// R24: switch_policy codes: 0 pin, 1 register, 2 revertive, 3 non-revertive.
package rss_pkg;

  // ----------------------------------------
  // operating modes and policies
  // ----------------------------------------
  localparam logic [1:0] OPM_SYNTH = 2'h0;
  localparam logic [1:0] OPM_HIGH_BW = 2'h1;
  localparam logic [1:0] OPM_LOW_BW = 2'h2;
  localparam logic [1:0] POL_MAN_PIN = 2'h0; // R24
  localparam logic [1:0] POL_MAN_REG = 2'h1; // R24
  localparam logic [1:0] POL_AUTO_REV = 2'h2; // R24
  localparam logic [1:0] POL_AUTO_NONREV = 2'h3; // R24

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_LAG = 4'h2;
  localparam logic [3:0] ADDR_SWCNT = 4'h3;
  localparam logic [7:0] RD_NONE = 8'h00;

  // ----------------------------------------
  // timing counts
  // ----------------------------------------
  localparam logic [1:0] BAD_FB_EDGES = 2'h3;
  localparam logic [3:0] SLEW_MAX_STEP = 4'h4;
  localparam logic [7:0] LAG_MAX = 8'hff;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {S_OFF, S_ACQ, S_LOCK, S_SLEW, S_HOLD} rss_state_t;

  typedef struct packed {
    logic [2:0] pad;
    logic ref_sel;
    logic [1:0] policy;
    logic [1:0] op_mode;
  } rss_ctrl_t;

  localparam rss_ctrl_t CTRL_RESET = '{pad: 3'h0, ref_sel: 1'b0,
                                       policy: POL_MAN_REG, op_mode: OPM_SYNTH};

  typedef struct packed {
    logic [1:0] pad;
    logic slewing;
    logic locked;
    logic b_bad;
    logic a_bad;
    logic ref_lost;
    logic active;
  } rss_status_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } rss_bus_req_t;

endpackage

// ===== core/rss_edge_sync.sv
/*
  two-stage synchroniser with rising-edge detect for one pin input.
  assumes the pin is asynchronous to clk and slower than clk by half.
*/
module rss_edge_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pin side
  input wire logic pin,
  // core side
  output logic level,
  output logic rise
);
  import rss_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } rss_sync_t;

  rss_sync_t q, d;

  // only s2 reads s1, keeping metastability off the logic
  always_comb begin
    d = q;
    d.s1 = pin;
    d.s2 = q.s1;
    d.s3 = q.s2;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign level = q.s2;
  assign rise = q.s2 & ~q.s3;
endmodule

// ===== core/rss_ref_monitor.sv
/*
  loss detector for one divided reference, judged against feedback edges.
  assumes both edge inputs are one-cycle pulses in the clk domain.
*/
module rss_ref_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // edges
  input wire logic ref_edge,
  input wire logic fb_edge,
  // status
  output logic invalid
);
  import rss_pkg::*;

  typedef struct packed {
    logic [1:0] cnt;
    logic bad;
  } rss_mon_t;

  rss_mon_t q, d;

  always_comb begin
    d = q;
    if (ref_edge) begin
      d.cnt = 2'h0; // R21
      d.bad = 1'b0; // R21
    end else if (fb_edge && q.cnt != BAD_FB_EDGES) begin
      d.cnt = q.cnt + 2'h1;
      d.bad = (q.cnt == BAD_FB_EDGES - 2'h1); // R21
    end
  end

  // starts invalid: no reference has been seen yet
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '{cnt: BAD_FB_EDGES, bad: 1'b1};
    end else begin
      q <= d;
    end
  end

  assign invalid = q.bad;
endmodule

// ===== core/rss_core.sv
/*
  reference selection, switchover and holdover control for a two-input
  frequency translator loop, with a small register file on a plain port.
  assumes divided references, loop feedback, select pin and frequency lock
  arrive as asynchronous pins; the register port is on clk.
*/
// Design decisions made here: the address map and the strobed register port.
module rss_core (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire rss_pkg::rss_bus_req_t bus_req,
  output logic [7:0] rdata,
  // reference and loop pins
  input wire logic ref_in_a,
  input wire logic ref_in_b,
  input wire logic fb_in,
  input wire logic ref_sel_pin,
  input wire logic freq_lock_in,
  // status pins
  output logic active_ref,
  output logic ref_a_invalid,
  output logic ref_b_invalid,
  output logic pll_locked,
  output logic ref_lost,
  output logic holdover,
  output logic free_run,
  // loop control
  output logic loop_on_xtal,
  output logic phase_track_en,
  output logic stretch_pulse,
  output logic [3:0] stretch_len
);
  import rss_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    rss_state_t st;
    logic active;
    logic measure;
    logic [7:0] lag;
    logic [7:0] since_fb;
    logic stretch;
    logic [3:0] stretch_len;
    logic [7:0] sw_cnt;
    logic locked;
    rss_ctrl_t ctrl;
    logic [7:0] rdata;
  } rss_core_t;

  rss_core_t q, d;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic a_rise;
  logic b_rise;
  logic fb_rise;
  logic sel_pin_s;
  logic lock_s;
  logic a_bad;
  logic b_bad;

  rss_edge_sync u_sync_a (
    .clk(clk),
    .rst(rst),
    .pin(ref_in_a),
    .level(),
    .rise(a_rise)
  );

  rss_edge_sync u_sync_b (
    .clk(clk),
    .rst(rst),
    .pin(ref_in_b),
    .level(),
    .rise(b_rise)
  );

  rss_edge_sync u_sync_fb (
    .clk(clk),
    .rst(rst),
    .pin(fb_in),
    .level(),
    .rise(fb_rise)
  );

  rss_edge_sync u_sync_sel (
    .clk(clk),
    .rst(rst),
    .pin(ref_sel_pin),
    .level(sel_pin_s),
    .rise()
  );

  rss_edge_sync u_sync_lock (
    .clk(clk),
    .rst(rst),
    .pin(freq_lock_in),
    .level(lock_s),
    .rise()
  );

  // ----------------------------------------
  // loss monitors
  // ----------------------------------------
  rss_ref_monitor u_mon_a (
    .clk(clk),
    .rst(rst),
    .ref_edge(a_rise),
    .fb_edge(fb_rise),
    .invalid(a_bad)
  );

  rss_ref_monitor u_mon_b (
    .clk(clk),
    .rst(rst),
    .ref_edge(b_rise),
    .fb_edge(fb_rise),
    .invalid(b_bad)
  );

  // ----------------------------------------
  // selection decision
  // ----------------------------------------
  logic translator;
  logic auto_mode;
  logic revertive;
  logic pref;
  logic chosen;
  logic [1:0] valid;
  logic target;
  logic want_hold;
  logic act_edge;
  logic [3:0] step;
  rss_status_t status;

  always_comb begin
    translator = (q.ctrl.op_mode == OPM_HIGH_BW) || (q.ctrl.op_mode == OPM_LOW_BW); // R1
    auto_mode = (q.ctrl.policy == POL_AUTO_REV) || (q.ctrl.policy == POL_AUTO_NONREV); // R2
    revertive = (q.ctrl.policy == POL_AUTO_REV);
    valid = {~b_bad, ~a_bad};
    pref = q.ctrl.ref_sel; // R8
    // the select pin is consulted in manual-pin mode and nowhere else
    chosen = (q.ctrl.policy == POL_MAN_PIN) ? sel_pin_s : q.ctrl.ref_sel; // R3 R4 R7
    target = q.active;
    want_hold = 1'b0;
    if (!auto_mode) begin
      target = chosen; // R4 R6
      want_hold = !valid[chosen]; // R5
    end else if (q.st == S_ACQ || q.st == S_OFF) begin
      // the other input is only read for the hold decision until lock, never made the target, so no hunting
      target = pref; // R9
      want_hold = !valid[0] && !valid[1]; // R11
    end else if (q.st == S_HOLD) begin
      // both valid gives the preferred one, else the first to recover
      target = valid[pref] ? pref : !pref; // R12 R19
      want_hold = !valid[0] && !valid[1]; // R11
    end else if (valid[q.active]) begin
      if (revertive && valid[pref]) begin
        target = pref; // R13
      end else begin
        target = q.active; // R10 R14
      end
    end else if (valid[!q.active]) begin
      target = !q.active; // R10
    end else begin
      want_hold = 1'b1; // R11
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    d = q;
    d.stretch = 1'b0;
    d.rdata = RD_NONE;
    act_edge = q.active ? b_rise : a_rise;
    step = 4'h0;
    status = '0;

    // clk cycles since the last feedback edge, saturating
    if (fb_rise) begin
      d.since_fb = 8'h00;
    end else if (q.since_fb != LAG_MAX) begin
      d.since_fb = q.since_fb + 8'h01;
    end

    unique case (q.st)
      S_OFF: begin
        if (translator) begin
          d.st = S_ACQ;
          d.active = target;
        end
      end
      S_ACQ: begin
        d.active = target; // R9
        if (want_hold) begin
          d.st = S_HOLD;
        end else if (lock_s && valid[target]) begin
          d.st = S_LOCK;
        end
      end
      S_LOCK, S_SLEW: begin
        if (want_hold) begin
          d.st = S_HOLD; // R5 R11
          d.lag = 8'h00; // R17
        end else if (target != q.active) begin
          d.st = S_SLEW; // R15
          d.active = target;
          d.measure = 1'b1;
          d.sw_cnt = q.sw_cnt + 8'h01;
        end else if (q.st == S_SLEW) begin
          if (q.measure) begin
            if (act_edge) begin
              // lag of the new reference behind the output, in clk cycles
              d.lag = q.since_fb; // R15
              d.measure = 1'b0;
            end
          end else if (fb_rise) begin
            if (q.lag == 8'h00) begin
              d.st = S_LOCK;
            end else begin
              // a bounded delay per period: slope limited and never shorter
              step = (q.lag > {4'h0, SLEW_MAX_STEP}) ? SLEW_MAX_STEP : q.lag[3:0]; // R15 R16
              d.lag = q.lag - {4'h0, step}; // R16
              d.stretch = 1'b1; // R16
              d.stretch_len = step;
            end
          end
        end
      end
      S_HOLD: begin
        // no phase steering at all while the references are gone
        d.lag = 8'h00; // R17
        if (!want_hold) begin
          d.st = S_SLEW; // R6 R19 R20
          d.active = target;
          d.measure = 1'b1;
          if (target != q.active) begin
            d.sw_cnt = q.sw_cnt + 8'h01;
          end
        end
      end
    endcase

    // synthesizer mode overrides the state, active reference, switch count, measure and lag updates
    if (!translator) begin
      d.st = S_OFF; // R1
      // no switch may be made or counted while the references are ignored
      d.active = q.active; // R1
      d.sw_cnt = q.sw_cnt;
      d.measure = 1'b0;
      d.lag = 8'h00;
    end

    d.locked = lock_s && (d.st == S_LOCK || d.st == S_SLEW); // R22

    status.active = q.active;
    status.ref_lost = (q.st == S_HOLD);
    status.a_bad = a_bad;
    status.b_bad = b_bad;
    status.locked = q.locked;
    status.slewing = (q.st == S_SLEW);

    // register port: write takes effect next cycle, read answers next cycle
    if (bus_req.wr && bus_req.addr == ADDR_CTRL) begin
      d.ctrl = rss_ctrl_t'({3'h0, bus_req.wdata[4:0]}); // R2 R4 R7
    end
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        ADDR_CTRL: d.rdata = q.ctrl;
        ADDR_STATUS: d.rdata = status;
        ADDR_LAG: d.rdata = q.lag;
        ADDR_SWCNT: d.rdata = q.sw_cnt;
        default: d.rdata = RD_NONE;
      endcase
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '{st: S_OFF, active: 1'b0, measure: 1'b0, lag: 8'h00,
             since_fb: LAG_MAX, stretch: 1'b0, stretch_len: 4'h0,
             sw_cnt: 8'h00, locked: 1'b0, ctrl: CTRL_RESET, rdata: RD_NONE};
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign rdata = q.rdata;
  assign active_ref = q.active; // R23
  assign ref_a_invalid = a_bad; // R21
  assign ref_b_invalid = b_bad; // R21
  assign pll_locked = q.locked; // R22
  assign ref_lost = (q.st == S_HOLD); // R5 R11
  assign holdover = (q.st == S_HOLD) && (q.ctrl.op_mode == OPM_LOW_BW);
  assign free_run = (q.st == S_HOLD) && (q.ctrl.op_mode == OPM_HIGH_BW);
  // the crystal stays the loop reference through low-bandwidth holdover
  assign loop_on_xtal = (q.ctrl.op_mode == OPM_LOW_BW) && (q.st != S_OFF); // R18
  assign phase_track_en = (q.st == S_LOCK) || (q.st == S_SLEW) || (q.st == S_ACQ); // R17
  assign stretch_pulse = q.stretch; // R16
  assign stretch_len = q.stretch_len;
endmodule

// ===== dv/rss_core_sva.sv
/*
  port assertions for rss_core.
  assumes one clk domain and the synchronous rst of the core.
*/
module rss_core_sva (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // watched pins
  input wire logic ref_in_a,
  input wire logic freq_lock_in,
  input wire logic active_ref,
  input wire logic ref_a_invalid,
  input wire logic pll_locked,
  input wire logic ref_lost,
  input wire logic holdover,
  input wire logic free_run,
  input wire logic loop_on_xtal,
  input wire logic phase_track_en,
  input wire logic stretch_pulse,
  input wire logic [3:0] stretch_len
);
  timeunit 1ns;
  timeprecision 1ps;
  import rss_pkg::*;
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // lock pin is synced twice then registered, so four low samples suffice
  sequence s_lock_gone;
    !freq_lock_in [*4];
  endsequence
  property p_hold_flag;
    (holdover || free_run) |-> ref_lost;
  endproperty
  property p_hold_kind;
    ref_lost |-> (holdover ^ free_run);
  endproperty
  property p_freeze;
    ref_lost |-> (!phase_track_en && !stretch_pulse);
  endproperty
  property p_xtal;
    holdover |-> loop_on_xtal;
  endproperty
  property p_stretch;
    stretch_pulse |-> (stretch_len != 4'h0 && stretch_len <= SLEW_MAX_STEP);
  endproperty
  property p_one_step;
    stretch_pulse |=> !stretch_pulse;
  endproperty
  property p_lock_drop;
    s_lock_gone |-> !pll_locked;
  endproperty
  property p_ref_clear;
    $rose(ref_in_a) |-> ##[1:6] !ref_a_invalid;
  endproperty
  property p_switch;
    $changed(active_ref) |-> phase_track_en;
  endproperty
  a_hold_flag: assert property (p_hold_flag) else $error("hold state without loss flag");
  a_hold_kind: assert property (p_hold_kind) else $error("loss flag without one hold kind");
  a_freeze: assert property (p_freeze) else $error("phase adjusted while lost");
  a_xtal: assert property (p_xtal) else $error("holdover off crystal");
  a_stretch: assert property (p_stretch) else $error("stretch length out of range");
  a_one_step: assert property (p_one_step) else $error("stretch pulse too long");
  a_lock_drop: assert property (p_lock_drop) else $error("lock kept after loss");
  a_ref_clear: assert property (p_ref_clear) else $error("invalid kept after edge");
  a_switch: assert property (p_switch) else $error("switch without tracking");
endmodule

bind rss_core rss_core_sva u_rss_core_sva (.clk(clk), .rst(rst), .ref_in_a(ref_in_a),
  .freq_lock_in(freq_lock_in), .active_ref(active_ref), .ref_a_invalid(ref_a_invalid),
  .pll_locked(pll_locked), .ref_lost(ref_lost), .holdover(holdover), .free_run(free_run),
  .loop_on_xtal(loop_on_xtal), .phase_track_en(phase_track_en),
  .stretch_pulse(stretch_pulse), .stretch_len(stretch_len));

// ===== dv/rss_ref_model.sv
/*
  two reference sources and loop feedback, period ten clk cycles.
  assumes enables change right after a clk edge; a stopped source stands low.
*/
module rss_ref_model (
  // clock
  input wire logic clk,
  // source enables
  input wire logic en_a,
  input wire logic en_b,
  // clocks
  output logic ref_a,
  output logic ref_b,
  output logic fb
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q = 4'h0;
  always @(posedge clk) begin
    cnt_q <= (cnt_q == 4'h9) ? 4'h0 : cnt_q + 4'h1;
  end
  // same phase on both sources so they turn valid together
  assign ref_a = en_a && (cnt_q < 4'h5);
  assign ref_b = en_b && (cnt_q < 4'h5);
  // feedback lags the references, so a switch always leaves some lag
  assign fb = (cnt_q >= 4'h6) || (cnt_q < 4'h1);
endmodule

// ===== dv/rss_core_tb.sv
/*
  self-checking bench for rss_core: register port, manual, automatic, holdover.
  assumes rss_ref_model supplies the references and feedback.
*/
module rss_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rss_pkg::*;
  localparam logic [7:0] ACT = 8'h01, LCK = 8'h02, LOST = 8'h04, FREE = 8'h08;
  localparam logic [7:0] HOLD = 8'h10, ABAD = 8'h20, BBAD = 8'h40;
  logic clk = 1'b0;
  logic rst = 1'b1;
  rss_bus_req_t bus_req = '0;
  logic en_a = 1'b1, en_b = 1'b1, sel_pin = 1'b0, lock_in = 1'b0;
  logic ref_a, ref_b, fb, act, a_bad, b_bad, locked, lost, hold, free, xtal, track;
  logic [7:0] rdata;
  int fails = 0;
  int n_compared = 0;
  wire logic [7:0] obs = {1'b0, b_bad, a_bad, hold, free, lost, locked, act};
  always #12.5 clk = ~clk;
  rss_ref_model u_rss_ref_model (.clk(clk), .en_a(en_a), .en_b(en_b), .ref_a(ref_a),
    .ref_b(ref_b), .fb(fb));
  rss_core u_rss_core (.clk(clk), .rst(rst), .bus_req(bus_req), .rdata(rdata),
    .ref_in_a(ref_a), .ref_in_b(ref_b), .fb_in(fb), .ref_sel_pin(sel_pin),
    .freq_lock_in(lock_in), .active_ref(act), .ref_a_invalid(a_bad),
    .ref_b_invalid(b_bad), .pll_locked(locked), .ref_lost(lost), .holdover(hold),
    .free_run(free), .loop_on_xtal(xtal), .phase_track_en(track), .stretch_pulse(),
    .stretch_len());
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    if (fails == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1 d = rdata;
  endtask
  // waits, bounded, for the masked status, then judges it
  task automatic chk_obs(input logic [7:0] m, input logic [7:0] v);
    int i;
    for (i = 0; i < 3000 && (obs & m) !== v; i++) begin
      @(posedge clk);
      #1;
    end
    if (i == 3000) begin
      fails++;
      test_done();
    end
    check(obs & m, v);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    logic [7:0] d;
    rd(ADDR_CTRL, d);
    check(d, {3'h0, 1'b0, POL_MAN_REG, OPM_SYNTH});
    wr(ADDR_CTRL, 8'hff);
    rd(ADDR_CTRL, d);
    check(d, 8'h1f);
    rd(4'h7, d);
    check(d, RD_NONE);
  endtask
  task automatic t_synth();
    lock_in <= 1'b1;
    wr(ADDR_CTRL, {3'h0, 1'b1, POL_MAN_REG, OPM_SYNTH});
    repeat (200) @(posedge clk);
    #1 check({track, obs[6:0] & 7'h1f}, 8'h00);
  endtask
  task automatic t_manual();
    sel_pin <= 1'b1;
    wr(ADDR_CTRL, {3'h0, 1'b0, POL_MAN_PIN, OPM_HIGH_BW});
    chk_obs(LCK | ACT, LCK | ACT);
    en_b <= 1'b0;
    chk_obs(BBAD | FREE | LOST | ACT, BBAD | FREE | LOST | ACT);
    en_b <= 1'b1;
    chk_obs(BBAD | LOST | ACT, ACT);
    wr(ADDR_CTRL, {3'h0, 1'b0, POL_MAN_REG, OPM_HIGH_BW});
    chk_obs(LCK | ACT, LCK);
    lock_in <= 1'b0;
    chk_obs(LCK, 8'h00);
    lock_in <= 1'b1;
  endtask
  task automatic t_auto();
    wr(ADDR_CTRL, {3'h0, 1'b0, POL_MAN_REG, OPM_SYNTH});
    en_a <= 1'b0;
    // the preferred input must already be flagged bad when acquisition starts
    chk_obs(ABAD, ABAD);
    wr(ADDR_CTRL, {3'h0, 1'b0, POL_AUTO_REV, OPM_LOW_BW});
    repeat (300) @(posedge clk);
    #1;
    chk_obs(LCK | ACT | LOST, 8'h00);
    en_a <= 1'b1;
    chk_obs(LCK | ACT, LCK);
    en_a <= 1'b0;
    chk_obs(LOST | ACT, ACT);
    en_a <= 1'b1;
    chk_obs(ACT, 8'h00);
    wr(ADDR_CTRL, {3'h0, 1'b0, POL_AUTO_NONREV, OPM_LOW_BW});
    en_a <= 1'b0;
    chk_obs(ACT, ACT);
    en_a <= 1'b1;
    repeat (300) @(posedge clk);
    #1;
    chk_obs(ACT | LOST, ACT);
  endtask
  task automatic t_hold();
    logic [7:0] d;
    // running on b while a is preferred, so the recovery pick is visible
    wr(ADDR_CTRL, {3'h0, 1'b0, POL_AUTO_NONREV, OPM_LOW_BW});
    en_a <= 1'b0;
    en_b <= 1'b0;
    chk_obs(HOLD | FREE | LOST, HOLD | LOST);
    check({6'h00, xtal, track}, 8'h02);
    en_a <= 1'b1;
    en_b <= 1'b1;
    chk_obs(LOST | ACT, 8'h00);
    wr(ADDR_CTRL, {3'h0, 1'b0, POL_AUTO_REV, OPM_HIGH_BW});
    en_a <= 1'b0;
    en_b <= 1'b0;
    chk_obs(FREE | LOST, FREE | LOST);
    en_b <= 1'b1;
    chk_obs(LOST | ACT, ACT);
    // let the slew finish before reading the status back
    repeat (100) @(posedge clk);
    rd(ADDR_STATUS, d);
    check(d, 8'h15);
    rd(ADDR_LAG, d);
    check(d, 8'h00);
    rd(ADDR_SWCNT, d);
    check(d, 8'h06);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_synth();
    t_manual();
    t_auto();
    t_hold();
    test_done();
  end
endmodule
